// >>> hdl/fan_speed_controller_defs.svh
// Constants for the fan speed controller: register map, fields, resets, timing.
//
// Overview of operation
// - Direct and closed-loop modes, both ramp and spin-up.
// - Direct drive write reaches output at once with ramp off and no spin-up.
// - Direct mode ramps only when ramp enable set.
// - Entering direct mode restores last written setting.
// - Closed loop: drive read-only, target read-write.
// - Loop steers drive by PID toward target count.
// - Target all ones switches drive off.
// - New target accepted anytime, loop follows it.
// - Loop off at reset, defaults need only target.
// - Count reference ticks across programmed pulse edges.
// - Measurement runs regardless of drive, may stall.
// - Period above valid limit flags a stall.
// - Loop keeps restarting stalled fan until valid.
// - Stall masked for spin-up time on direct-mode entry and on each spin-up start.
// - Direct mode sets stall in any cycle period too long once the stall mask has expired.
// - Loop checks stall only at update ticks.
// - Full drive missing target band flags shortfall.
// - Reference pin as output drives measurement clock.
// - Reference from pin or internal divider, configurable.
// - Direct setting zero to nonzero starts spin-up.
// - Ramp moves at most step per update period.
`ifndef FAN_SPEED_CONTROLLER_DEFS_SVH
`define FAN_SPEED_CONTROLLER_DEFS_SVH
// ****************************************************************
// Register word indexes
// ****************************************************************
`define REG_DRIVE 4'h0
`define REG_CONFIG 4'h1
`define REG_SPINUP 4'h2
`define REG_MAX_STEP 4'h3
`define REG_MIN_DRIVE 4'h4
`define REG_VALID 4'h5
`define REG_TARGET 4'h6
`define REG_READING 4'h7
`define REG_BAND 4'h8
`define REG_STATUS 4'h9
// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_LOOP 0
`define CFG_RAMP 1
`define CFG_CLK_EXT 2
`define CFG_CLK_OUT 3
`define CFG_UPD_LSB 4
`define CFG_EDGE_LSB 7
`define CFG_FAIL_LSB 9
`define SPN_TIME_LSB 0
`define SPN_LVL_LSB 2
`define SPN_FULL 5
`define STS_STALL 0
`define STS_DFAIL 1
// ****************************************************************
// Reset values
// ****************************************************************
`define UPD_SEL_RST 3'h2
`define EDGE_SEL_RST 2'h1
`define FAIL_SEL_RST 2'h1
`define SPIN_SEL_RST 2'h1
`define LEVEL_RST 3'h3
`define MAX_STEP_RST 5'h10
`define MIN_DRIVE_RST 8'h66
`define VALID_RST 8'hf5
`define TARGET_RST 8'hff
`define BAND_RST 8'h10
`define COUNT_MAX 8'hff
`define DRIVE_FULL 8'hff
// ****************************************************************
// Timing
// ****************************************************************
`define SYS_CLK_HZ 10000000
`define REF_HZ 32768
`define REF_HALF_DIV (`SYS_CLK_HZ / (2 * `REF_HZ))
`define UPDATE_BASE_MS 100
`define UPDATE_BASE_TICKS ((`REF_HZ * `UPDATE_BASE_MS) / 1000)
`define SPIN_BASE_MS 250
`define SPIN_BASE_TICKS ((`REF_HZ * `SPIN_BASE_MS) / 1000)
`endif

// >>> hdl/fan_speed_controller_pkg.sv
// Types shared by the fan speed controller.
package fan_speed_controller_pkg;
`include "fan_speed_controller_defs.svh"
    localparam int unsigned AVS_ADDR_W = 4;
    localparam int unsigned AVS_DATA_W = 32;
    typedef enum logic [1:0] {
        SPIN_IDLE = 2'b00,
        SPIN_FULL = 2'b01,
        SPIN_LEVEL = 2'b11
    } spin_state_t;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] setting;
        logic [7:0] drive;
        logic loop;
        logic ramp;
        logic clk_ext;
        logic clk_out;
        logic [2:0] upd_sel;
        logic [1:0] edge_sel;
        logic [1:0] fail_sel;
        logic [1:0] spin_sel;
        logic [2:0] level;
        logic full_en;
        logic [4:0] max_step;
        logic [7:0] min_drive;
        logic [7:0] valid;
        logic [7:0] target;
        logic [7:0] reading;
        logic [7:0] band;
        logic stall;
        logic dfail;
        logic [7:0] div;
        logic ref_out;
        logic ref_prev;
        logic tach_prev;
        logic [7:0] tach_cnt;
        logic [3:0] edge_cnt;
        logic [15:0] upd_cnt;
        spin_state_t spin;
        logic [16:0] spin_cnt;
        logic [16:0] mask_cnt;
        logic signed [11:0] integ;
        logic signed [8:0] prev_err;
        logic [3:0] fail_cnt;
    } state_t;
endpackage

// >>> hdl/fan_speed_controller.sv
// Fan drive controller with direct and closed-loop speed modes.
`timescale 1ns/1ps
`include "fan_speed_controller_defs.svh"
module fan_speed_controller #(
    parameter int UPDATE_BASE_TICKS = `UPDATE_BASE_TICKS,
    parameter int SPIN_BASE_TICKS = `SPIN_BASE_TICKS
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Avalon-MM slave.
    input wire logic [fan_speed_controller_pkg::AVS_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [fan_speed_controller_pkg::AVS_DATA_W-1:0] i_avs_writedata,
    output logic [fan_speed_controller_pkg::AVS_DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Fan side.
    input wire logic i_tach,
    output logic [7:0] o_fan_drive,
    output logic o_alert,
    // Reference clock pin.
    input wire logic i_ref_clk_in,
    output logic o_ref_clk_out,
    output logic o_ref_clk_oe_n
);
    import fan_speed_controller_pkg::*;

    state_t r;
    state_t n;
    logic req;
    logic wr_fire;
    logic [31:0] wd;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                               input logic [7:0] tgt,
                                               input logic [4:0] st);
        logic [7:0] s;
        s = (st == 5'h0) ? 8'h1 : {3'h0, st};
        if (tgt > cur) begin
            step_toward = (tgt - cur > s) ? cur + s : tgt;
        end else if (cur > tgt) begin
            step_toward = (cur - tgt > s) ? cur - s : tgt;
        end else begin
            step_toward = cur;
        end
    endfunction

    // Spin level runs from 30 percent to 65 percent of full drive.
    function automatic logic [7:0] level_drive(input logic [2:0] lvl);
        int unsigned pct;
        pct = 30 + 5 * int'(lvl);
        level_drive = 8'((pct * 255) / 100);
    endfunction

    assign req = i_avs_read | i_avs_write;
    assign wr_fire = i_avs_write & r.ack;
    assign wd = i_avs_writedata;
    assign o_avs_waitrequest = req & ~r.ack;
    assign o_avs_readdata = r.rdata;
    assign o_fan_drive = r.drive;
    assign o_alert = r.stall | r.dfail;
    assign o_ref_clk_out = r.ref_out;
    assign o_ref_clk_oe_n = ~(r.clk_out & ~r.clk_ext);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic tick;
        logic int_tick;
        logic upd_tick;
        logic start_spin;
        logic [15:0] upd_len;
        logic [16:0] spin_len;
        logic [3:0] n_edges;
        logic signed [8:0] err;
        logic signed [9:0] derr;
        logic signed [12:0] isum;
        logic signed [13:0] delta;
        logic signed [13:0] lim;
        logic signed [10:0] nd;
        tick = 1'b0;
        int_tick = 1'b0;
        upd_tick = 1'b0;
        start_spin = 1'b0;
        upd_len = 16'(UPDATE_BASE_TICKS) << ((r.upd_sel > 3'h4) ? 3'h4 : r.upd_sel);
        spin_len = 17'(SPIN_BASE_TICKS) << r.spin_sel;
        n_edges = {1'b0, r.edge_sel, 1'b1} + 4'h2;
        err = $signed({1'b0, r.reading}) - $signed({1'b0, r.target});
        derr = 10'(err) - 10'(r.prev_err);
        isum = 13'(r.integ) + 13'(err);
        delta = 14'(err >>> 2) + 14'(r.integ >>> 4) + 14'(derr >>> 3);
        lim = $signed({9'h0, (r.max_step == 5'h0) ? 5'h1 : r.max_step});
        nd = '0;
        n = r;

        // Bus handshake: answer one cycle after the request appears.
        n.ack = req & ~r.ack;
        if (req && !r.ack) begin
            unique case (i_avs_address)
                `REG_DRIVE: n.rdata = {24'h0, r.drive};
                `REG_CONFIG: n.rdata = {21'h0, r.fail_sel, r.edge_sel, r.upd_sel,
                                        r.clk_out, r.clk_ext, r.ramp, r.loop};
                `REG_SPINUP: n.rdata = {26'h0, r.full_en, r.level, r.spin_sel};
                `REG_MAX_STEP: n.rdata = {27'h0, r.max_step};
                `REG_MIN_DRIVE: n.rdata = {24'h0, r.min_drive};
                `REG_VALID: n.rdata = {24'h0, r.valid};
                `REG_TARGET: n.rdata = {24'h0, r.target};
                `REG_READING: n.rdata = {24'h0, r.reading};
                `REG_BAND: n.rdata = {24'h0, r.band};
                `REG_STATUS: n.rdata = {30'h0, r.dfail, r.stall};
                default: n.rdata = 32'h0;
            endcase
        end

        // Plain register writes and write-one-to-clear status.
        if (wr_fire) begin
            unique case (i_avs_address)
                `REG_CONFIG: begin
                    n.loop = wd[`CFG_LOOP];
                    n.ramp = wd[`CFG_RAMP];
                    n.clk_ext = wd[`CFG_CLK_EXT];
                    n.clk_out = wd[`CFG_CLK_OUT];
                    n.upd_sel = wd[`CFG_UPD_LSB +: 3];
                    n.edge_sel = wd[`CFG_EDGE_LSB +: 2];
                    n.fail_sel = wd[`CFG_FAIL_LSB +: 2];
                end
                `REG_SPINUP: begin
                    n.spin_sel = wd[`SPN_TIME_LSB +: 2];
                    n.level = wd[`SPN_LVL_LSB +: 3];
                    n.full_en = wd[`SPN_FULL];
                end
                `REG_MAX_STEP: n.max_step = wd[4:0];
                `REG_MIN_DRIVE: n.min_drive = wd[7:0];
                `REG_VALID: n.valid = wd[7:0];
                `REG_TARGET: n.target = wd[7:0];
                `REG_BAND: n.band = wd[7:0];
                `REG_STATUS: begin
                    n.stall = r.stall & ~wd[`STS_STALL];
                    n.dfail = r.dfail & ~wd[`STS_DFAIL];
                end
                default: begin
                end
            endcase
        end

        // Reference tick, from the pin or from the internal divider.
        n.ref_prev = i_ref_clk_in;
        if (r.div == 8'(`REF_HALF_DIV - 1)) begin
            n.div = 8'h0;
            n.ref_out = ~r.ref_out;
            int_tick = ~r.ref_out;
        end else begin
            n.div = r.div + 8'h1;
        end
        tick = r.clk_ext ? (i_ref_clk_in & ~r.ref_prev) : int_tick;

        // Update period timer.
        if (tick) begin
            if (r.upd_cnt >= upd_len - 16'h1) begin
                n.upd_cnt = 16'h0;
                upd_tick = 1'b1;
            end else begin
                n.upd_cnt = r.upd_cnt + 16'h1;
            end
        end

        // Period measurement runs in both modes at any drive.
        n.tach_prev = i_tach;
        if (tick) begin
            if (r.tach_cnt != `COUNT_MAX) begin
                n.tach_cnt = r.tach_cnt + 8'h1;
            end else begin
                n.reading = `COUNT_MAX;
            end
        end
        if (i_tach ^ r.tach_prev) begin
            if (r.edge_cnt == 4'h0) begin
                n.edge_cnt = 4'h1;
                n.tach_cnt = 8'h0;
            end else if (r.edge_cnt + 4'h1 == n_edges) begin
                n.reading = r.tach_cnt;
                n.edge_cnt = 4'h1;
                n.tach_cnt = 8'h0;
            end else begin
                n.edge_cnt = r.edge_cnt + 4'h1;
            end
        end

        // Stall mask and spin-up sequence.
        if (tick && r.mask_cnt != 17'h0) begin
            n.mask_cnt = r.mask_cnt - 17'h1;
        end
        unique case (r.spin)
            SPIN_IDLE: begin
            end
            SPIN_FULL: begin
                n.drive = `DRIVE_FULL;
                if (tick) begin
                    n.spin_cnt = r.spin_cnt - 17'h1;
                    if (r.spin_cnt - 17'h1 <= spin_len - (spin_len >> 2)) begin
                        n.spin = SPIN_LEVEL;
                    end
                end
            end
            SPIN_LEVEL: begin
                n.drive = level_drive(r.level);
                if (tick) begin
                    n.spin_cnt = r.spin_cnt - 17'h1;
                    if (r.spin_cnt <= 17'h1) begin
                        n.spin = SPIN_IDLE;
                    end
                end
            end
            default: n.spin = SPIN_IDLE;
        endcase

        if (!r.loop) begin
            if (r.spin == SPIN_IDLE) begin
                if (!r.ramp) begin
                    n.drive = r.setting;
                end else if (upd_tick) begin
                    n.drive = step_toward(r.drive, r.setting, r.max_step);
                end
            end
            if (r.mask_cnt == 17'h0 && r.reading > r.valid) begin
                n.stall = 1'b1;
            end
        end else if (r.target == `COUNT_MAX) begin
            n.drive = 8'h0;
            n.spin = SPIN_IDLE;
        end else if (r.spin == SPIN_IDLE && upd_tick) begin
            if (r.reading > r.valid) begin
                if (r.mask_cnt == 17'h0) begin
                    n.stall = 1'b1;
                end
                start_spin = 1'b1;
            end else begin
                // PID step, clamped to the maximum step and the drive floor.
                n.integ = (isum > 13'sd2047) ? 12'sd2047 :
                          (isum < -13'sd2048) ? 12'sh800 : 12'(isum);
                n.prev_err = err;
                if (delta > lim) begin
                    delta = lim;
                end else if (delta < -lim) begin
                    delta = -lim;
                end
                nd = $signed({3'h0, r.drive}) + 11'(delta);
                if (nd > 11'sd255) begin
                    n.drive = `DRIVE_FULL;
                end else if (nd < $signed({3'h0, r.min_drive})) begin
                    n.drive = r.min_drive;
                end else begin
                    n.drive = nd[7:0];
                end
            end
            if (r.drive == `DRIVE_FULL &&
                {1'b0, r.reading} > {1'b0, r.target} + {1'b0, r.band}) begin
                if (r.fail_cnt == {r.fail_sel, 2'h3}) begin
                    n.dfail = 1'b1;
                end else begin
                    n.fail_cnt = r.fail_cnt + 4'h1;
                end
            end else begin
                n.fail_cnt = 4'h0;
            end
        end

        // Mode entries and register effects that override the above.
        if (wr_fire && i_avs_address == `REG_CONFIG) begin
            if (r.loop && !wd[`CFG_LOOP]) begin
                n.drive = r.setting;
                n.spin = SPIN_IDLE;
                n.mask_cnt = spin_len;
                start_spin = 1'b0;
            end
            if (!r.loop && wd[`CFG_LOOP]) begin
                n.integ = '0;
                n.prev_err = '0;
                n.fail_cnt = 4'h0;
            end
        end
        if (wr_fire && i_avs_address == `REG_TARGET && r.loop &&
            r.target == `COUNT_MAX && wd[7:0] < r.valid) begin
            start_spin = 1'b1;
        end
        if (wr_fire && i_avs_address == `REG_DRIVE && !r.loop) begin
            n.setting = wd[7:0];
            if (r.setting == 8'h0 && wd[7:0] != 8'h0) begin
                start_spin = 1'b1;
            end else if (!r.ramp && r.spin == SPIN_IDLE) begin
                n.drive = wd[7:0];
            end
        end
        if (start_spin) begin
            // Spin-up drive lands with its trigger, so no cycle of the old level shows.
            n.drive = r.full_en ? `DRIVE_FULL : level_drive(r.level);
            n.spin = r.full_en ? SPIN_FULL : SPIN_LEVEL;
            n.spin_cnt = spin_len;
            n.mask_cnt = spin_len;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.spin <= SPIN_IDLE;
            // The speed line idles high, so a low start value would fake an edge.
            r.tach_prev <= 1'b1;
            r.upd_sel <= `UPD_SEL_RST;
            r.edge_sel <= `EDGE_SEL_RST;
            r.fail_sel <= `FAIL_SEL_RST;
            r.spin_sel <= `SPIN_SEL_RST;
            r.level <= `LEVEL_RST;
            r.full_en <= 1'b1;
            r.max_step <= `MAX_STEP_RST;
            r.min_drive <= `MIN_DRIVE_RST;
            r.valid <= `VALID_RST;
            r.target <= `TARGET_RST;
            r.band <= `BAND_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    a_bus_answer: assert property (req && !r.ack |=> !o_avs_waitrequest || !req)
        else $error("bus answer late");
    a_direct_write: assert property (wr_fire && i_avs_address == `REG_DRIVE && !r.loop &&
        !r.ramp && r.spin == SPIN_IDLE && (r.setting != 8'h0 || wd[7:0] == 8'h0)
        |=> o_fan_drive == $past(wd[7:0]))
        else $error("direct write not immediate");
    a_setting_readonly: assert property (r.loop |=> $stable(r.setting))
        else $error("setting changed in loop mode");
    a_target_off: assert property (r.loop && r.target == `COUNT_MAX |=>
        o_fan_drive == 8'h0 || r.target != `COUNT_MAX || !r.loop)
        else $error("drive not off for all-ones target");
    a_direct_entry: assert property ($fell(r.loop) |-> o_fan_drive == $past(r.setting))
        else $error("direct entry drive wrong");
    a_direct_stall: assert property (!r.loop && r.mask_cnt == 17'h0 &&
        r.reading > r.valid |=> r.stall)
        else $error("stall not flagged");
    a_stall_sticky: assert property (r.stall && !(wr_fire &&
        i_avs_address == `REG_STATUS && wd[`STS_STALL]) |=> r.stall ##0 o_alert)
        else $error("stall flag dropped");
    a_period_sat: assert property (r.tach_cnt == `COUNT_MAX &&
        !(i_tach ^ r.tach_prev) |=> r.tach_cnt == `COUNT_MAX)
        else $error("period counter wrapped");
    a_spin_full: assert property (r.spin == SPIN_FULL && !r.loop |->
        o_fan_drive == `DRIVE_FULL || $past(r.spin) != SPIN_FULL)
        else $error("spin-up not at full drive");

    c_direct_write: cover property (wr_fire && i_avs_address == `REG_DRIVE && !r.loop);
    c_spin_level: cover property (r.spin == SPIN_FULL ##1 r.spin == SPIN_LEVEL);
    c_stall_flag: cover property (!r.stall ##1 r.stall);
    c_loop_step: cover property (r.loop ##1 r.loop && o_fan_drive != $past(o_fan_drive));
    c_ref_external: cover property (r.clk_ext && r.reading != 8'h0);
endmodule

// >>> tb/fan_model.sv
// Three-wire fan model with an open-drain speed pulse and a pull-up.
`timescale 1ns/1ps
module fan_model (
    // Clock and control.
    input wire logic i_clock,
    input wire logic i_run,
    input wire logic [15:0] i_half,
    // Speed pulse.
    output logic o_tach
);
    logic [15:0] cnt = 16'h0;
    initial o_tach = 1'b1;
    // A stopped fan releases the line, so the pull-up holds it high.
    always @(posedge i_clock) begin
        if (!i_run) begin
            o_tach <= 1'b1;
            cnt <= 16'h0;
        end else if (cnt >= i_half - 16'h1) begin
            o_tach <= !o_tach;
            cnt <= 16'h0;
        end else begin
            cnt <= cnt + 16'h1;
        end
    end
endmodule

// >>> tb/fan_speed_controller_tb.sv
// Self-checking bench for the fan speed controller.
`timescale 1ns/1ps
module fan_speed_controller_tb;
    import fan_speed_controller_pkg::*;
    typedef struct {string n; logic [31:0] e; int t;} note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic ref_in = 1'b0;
    logic run = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq, tach, alert, ref_out, oe_n;
    logic [7:0] drive, v, v2;
    logic [7:0] ref_cnt = 8'h0;
    logic ref_seen;
    note_t q[$];
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [3:0] ra[10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'h0, 4'hf};
    logic [31:0] re[10] = '{32'h2a0, 32'h2d, 32'h10, 32'h66, 32'hf5, 32'hff, 32'h10, 32'h0,
        32'h0, 32'h0};

    always #50 clk = ~clk;
    // A half period of 153 clocks is the nearest whole count to the reference rate.
    always @(posedge clk) begin
        ref_cnt <= (ref_cnt == 8'd152) ? 8'd0 : ref_cnt + 8'd1;
        if (ref_cnt == 8'd152) begin
            ref_in <= ~ref_in;
        end
    end

    fan_model fan_model_i (.i_clock(clk), .i_run(run), .i_half(16'd1520), .o_tach(tach));

    fan_speed_controller #(.UPDATE_BASE_TICKS(4), .SPIN_BASE_TICKS(8)) fan_speed_controller_i (
        .i_clock(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_tach(tach), .o_fan_drive(drive), .o_alert(alert),
        .i_ref_clk_in(ref_in), .o_ref_clk_out(ref_out), .o_ref_clk_oe_n(oe_n));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic compare(input string n, input logic [31:0] e, input logic [31:0] g,
        input int t);
        logic [31:0] d;
        d = (g > e) ? g - e : e - g;
        checks++;
        if (^g === 1'bx || (t == 0 ? g !== e : d > t)) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic read_expect(input logic [3:0] a, input string n, input logic [31:0] e,
        input int t);
        q.push_back('{n, e, t});
        bus(1'b0, a, 32'h0);
    endtask

    task final_report;
        $display("Checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        note_t nt;
        if (rd && waitreq === 1'b0) begin
            if (q.size() == 0) begin
                num_errors++;
                $display("Error read data expected none seen %h", rdata);
            end else begin
                nt = q.pop_front();
                compare(nt.n, nt.e, rdata, nt.t);
            end
        end
    end

    // The run needs about 50000 cycles; the ceiling leaves a margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            final_report();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(58074));
        v = 8'h20 + 8'($urandom % 128);
        v2 = 8'h20 + 8'($urandom % 128);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) read_expect(ra[i], "reset value", re[i], 0);
        bus(1'b1, 4'hf, 32'h5a);
        read_expect(4'hf, "unmapped", 32'h0, 0);
        $display("Reset values done");
        bus(1'b1, 4'h0, {24'h0, v});
        #1 compare("spin-up drive", 32'hff, {24'h0, drive}, 0);
        compare("masked alert", 32'h0, {31'h0, alert}, 0);
        repeat (8000) @(posedge clk);
        #1 compare("drive after spin-up", {24'h0, v}, {24'h0, drive}, 0);
        read_expect(4'h7, "period count", 32'd20, 1);
        bus(1'b1, 4'h5, 32'h8);
        repeat (6500) @(posedge clk);
        read_expect(4'h9, "stall flag", 32'h1, 0);
        #1 compare("stall alert", 32'h1, {31'h0, alert}, 0);
        bus(1'b1, 4'h5, 32'hf5);
        repeat (6500) @(posedge clk);
        read_expect(4'h9, "sticky stall", 32'h1, 0);
        bus(1'b1, 4'h9, 32'h1);
        read_expect(4'h9, "cleared status", 32'h0, 0);
        #1 compare("cleared alert", 32'h0, {31'h0, alert}, 0);
        $display("Direct mode and stall done");
        bus(1'b1, 4'h0, {24'h0, v2});
        #1 compare("direct drive", {24'h0, v2}, {24'h0, drive}, 0);
        bus(1'b1, 4'h1, 32'h2a1);
        bus(1'b1, 4'h0, 32'h33);
        repeat (5200) @(posedge clk);
        #1 compare("target off drive", 32'h0, {24'h0, drive}, 0);
        bus(1'b1, 4'h6, 32'h30);
        read_expect(4'h6, "target", 32'h30, 0);
        bus(1'b1, 4'h1, 32'h2a0);
        #1 compare("direct restore", {24'h0, v2}, {24'h0, drive}, 0);
        $display("Closed loop done");
        bus(1'b1, 4'h3, 32'h4);
        bus(1'b1, 4'h1, 32'h2a2);
        bus(1'b1, 4'h0, {24'h0, v2 + 8'd40});
        #1 compare("ramp start", {24'h0, v2} + 32'd2, {24'h0, drive}, 2);
        repeat (5200) @(posedge clk);
        #1 compare("ramp period", {24'h0, v2} + 32'd8, {24'h0, drive}, 4);
        bus(1'b1, 4'h1, 32'h2a8);
        #1 compare("ref pin enable", 32'h0, {31'h0, oe_n}, 0);
        ref_seen = ref_out;
        repeat (152) @(posedge clk);
        #1 compare("ref pin clock", {31'h0, ~ref_seen}, {31'h0, ref_out}, 0);
        bus(1'b1, 4'h1, 32'h2a4);
        #1 compare("ref pin released", 32'h1, {31'h0, oe_n}, 0);
        repeat (12500) @(posedge clk);
        read_expect(4'h7, "external period", 32'd20, 1);
        bus(1'b1, 4'h0, 32'h90);
        #1 compare("direct drive", 32'h90, {24'h0, drive}, 0);
        bus(1'b1, 4'h1, 32'h2a5);
        repeat (5200) @(posedge clk);
        #1 compare("loop step", 32'h8a, {24'h0, drive}, 2);
        $display("Ramp, reference pin and loop done");
        final_report();
    end
endmodule
